//--- hdl/tlpic_top.v
/*
 Two-level priority interrupt controller with APB register access.
 Assumes the core sequencer acknowledges vector requests and signals
 the return instruction with a one-cycle pulse, all on pclk.
*/
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tlpic_regs.vh"
module tlpic_top #(
   parameter NP = 5                      // Peripheral sources
) (
   input  wire          pclk,            // Clock, 10 MHz
   input  wire          presetn,         // Async reset, active low
   input  wire          psel,            // APB select
   input  wire          penable,         // APB enable
   input  wire          pwrite,          // APB direction
   input  wire [11:0]   paddr,           // APB byte address
   input  wire [31:0]   pwdata,          // APB write data
   output reg  [31:0]   prdata,          // APB read data
   output reg           pready,          // APB ready
   output reg           pslverr,         // APB error
   input  wire          pin0_event,      // External pin level
   input  wire          port_change,     // Port change level
   input  wire          timer0_overflow, // Timer pulse, pclk domain
   input  wire [NP-1:0] periph_event,    // Peripheral pulses
   input  wire          vec_ack,         // Core took the vector
   input  wire          return_from_isr, // Return instruction pulse
   output reg           vec_req,         // Vector request to core
   output reg  [15:0]   vec_addr,        // Vector address
   output reg           push_ret         // Push return address
);
   localparam N = NP + 3;
   localparam S_IDLE = 3'b001;
   localparam S_REQ  = 3'b010;
   localparam S_WAIT = 3'b100;

   reg  [7:0]    main_q;
   reg           prio_en_q;
   reg  [NP-1:0] pflag_q;
   reg  [NP-1:0] pen_q;
   reg  [N-1:0]  pri_q;
   reg           in_high_q;
   reg           in_low_q;
   reg           low_pend_q;
   reg           pend_is_high_q;
   reg           ent_h_q;
   reg           ent_l_q;
   reg  [2:0]    state_q;
   wire [1:0]    pin_rise;
   wire          take_high;
   wire          take_low;

   tlpic_sync #(.W(2)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({port_change, pin0_event}),
      .rise     (pin_rise)
   );

   // Source order: 0 port change, 1 pin0, 2 timer0, then peripherals
   wire [N-1:0] flag_v = {pflag_q, main_q[`TLPIC_MAIN_T0IF],
                          main_q[`TLPIC_MAIN_P0IF], main_q[`TLPIC_MAIN_PCIF]};
   wire [N-1:0] en_v   = {pen_q, main_q[`TLPIC_MAIN_T0IE],
                          main_q[`TLPIC_MAIN_P0IE], main_q[`TLPIC_MAIN_PCIE]};
   wire [N-1:0] per_v  = {{NP{1'b1}}, 3'b000};

   tlpic_arb #(.N(N)) u_arb (
      .flag      (flag_v),
      .en        (en_v),
      .pri       (pri_q),
      .periph    (per_v),
      .prio_mode (prio_en_q),
      .hi_gate   (main_q[`TLPIC_MAIN_HGEN]),
      .lo_gate   (main_q[`TLPIC_MAIN_LGEN]),
      .in_high   (in_high_q),
      .in_low    (in_low_q & ~prio_en_q),
      .take_high (take_high),
      .take_low  (take_low)
   );

   // APB: zero-wait, write and read take effect in the access cycle
   wire acc = psel & penable;
   wire wr  = acc & pwrite;
   wire hit = (paddr == `TLPIC_OFF_MAIN) | (paddr == `TLPIC_OFF_RESETCTL)
            | (paddr == `TLPIC_OFF_SRCFLAG) | (paddr == `TLPIC_OFF_SRCEN)
            | (paddr == `TLPIC_OFF_SRCPRI) | (paddr == `TLPIC_OFF_STATUS);
   wire wr_main = wr & (paddr == `TLPIC_OFF_MAIN);
   wire wr_pf   = wr & (paddr == `TLPIC_OFF_SRCFLAG);

   // Entry and return effects on the global enables
   wire enter = (state_q == S_IDLE) & (take_high | take_low);
   wire ret_h = return_from_isr & in_high_q;
   wire ret_l = return_from_isr & ~in_high_q & in_low_q;

   reg [7:0] main_d;
   always @* begin
      main_d = main_q;
      if (wr_main)
         main_d = pwdata[7:0];
      // Set wins over software clear on every event flag
      if (timer0_overflow)
         main_d[`TLPIC_MAIN_T0IF] = 1'b1;
      if (pin_rise[0])
         main_d[`TLPIC_MAIN_P0IF] = 1'b1;
      if (pin_rise[1])
         main_d[`TLPIC_MAIN_PCIF] = 1'b1;
      if (enter & (take_high | ~prio_en_q))
         main_d[`TLPIC_MAIN_HGEN] = 1'b0;
      if (enter & take_low & ~take_high)
         main_d[`TLPIC_MAIN_LGEN] = 1'b0;
      if (ret_h & ent_h_q)
         main_d[`TLPIC_MAIN_HGEN] = 1'b1;
      if (ret_l & ent_l_q)
         main_d[`TLPIC_MAIN_LGEN] = 1'b1;
      if (ret_l & ~prio_en_q)
         main_d[`TLPIC_MAIN_HGEN] = 1'b1;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_q    <= `TLPIC_MAIN_RESET;
         prio_en_q <= 1'b0;
         pflag_q   <= {NP{1'b0}};
         pen_q     <= {NP{1'b0}};
         pri_q     <= {N{1'b1}};
      end else begin
         main_q <= main_d;
         if (wr & (paddr == `TLPIC_OFF_RESETCTL))
            prio_en_q <= pwdata[`TLPIC_RCTL_PRIEN];
         pflag_q <= (wr_pf ? pwdata[NP-1:0] : pflag_q) | periph_event;
         if (wr & (paddr == `TLPIC_OFF_SRCEN))
            pen_q <= pwdata[NP-1:0];
         if (wr & (paddr == `TLPIC_OFF_SRCPRI))
            pri_q <= pwdata[N-1:0];
      end
   end

   // Vectoring sequence towards the core
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q        <= S_IDLE;
         vec_req        <= 1'b0;
         vec_addr       <= `TLPIC_VEC_HIGH;
         push_ret       <= 1'b0;
         in_high_q      <= 1'b0;
         in_low_q       <= 1'b0;
         low_pend_q     <= 1'b0;
         pend_is_high_q <= 1'b0;
         ent_h_q        <= 1'b0;
         ent_l_q        <= 1'b0;
      end else begin
         push_ret <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (take_high | take_low) begin
                  vec_req        <= 1'b1;
                  push_ret       <= 1'b1;
                  pend_is_high_q <= take_high;
                  vec_addr       <= (take_high | ~prio_en_q) ? `TLPIC_VEC_HIGH
                                                             : `TLPIC_VEC_LOW;
                  state_q        <= S_REQ;
               end
            end
            S_REQ: begin
               if (vec_ack) begin
                  vec_req <= 1'b0;
                  state_q <= S_WAIT;
                  if (pend_is_high_q) begin
                     // Preempted low routine resumes after the high return
                     low_pend_q <= in_low_q;
                     in_high_q  <= 1'b1;
                     ent_h_q    <= 1'b1;
                  end else begin
                     in_low_q   <= 1'b1;
                     ent_l_q    <= 1'b1;
                  end
               end
            end
            S_WAIT: state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
         if (ret_h) begin
            in_high_q <= 1'b0;
            ent_h_q   <= 1'b0;
            in_low_q  <= low_pend_q;
            // Preempted marker only lives until the high return
            low_pend_q <= 1'b0;
         end else if (ret_l) begin
            in_low_q <= 1'b0;
            ent_l_q  <= 1'b0;
         end
      end
   end

   // APB answers in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `TLPIC_OFF_MAIN:     prdata <= {24'h00_0000, main_q};
               `TLPIC_OFF_RESETCTL: prdata <= {24'h00_0000, prio_en_q, 7'h00};
               `TLPIC_OFF_SRCFLAG:  prdata <= {{(32-NP){1'b0}}, pflag_q};
               `TLPIC_OFF_SRCEN:    prdata <= {{(32-NP){1'b0}}, pen_q};
               `TLPIC_OFF_SRCPRI:   prdata <= {{(32-N){1'b0}}, pri_q};
               `TLPIC_OFF_STATUS:   prdata <= {29'h0000_0000, low_pend_q,
                                               in_low_q, in_high_q};
               default:             prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   // Erratic when software rewrites control during an enabled interrupt
   // Software must clear flags before re-enabling
endmodule
`default_nettype wire

//--- hdl/tlpic_regs.vh
/*
 Register offsets, field positions, reset values and timing counts
 for the two-level priority interrupt controller.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TLPIC_REGS_VH
`define TLPIC_REGS_VH

// Byte addresses on the APB register bus
`define TLPIC_OFF_MAIN      12'h000
`define TLPIC_OFF_RESETCTL  12'h004
`define TLPIC_OFF_SRCFLAG   12'h008
`define TLPIC_OFF_SRCEN     12'h00C
`define TLPIC_OFF_SRCPRI    12'h010
`define TLPIC_OFF_STATUS    12'h014

// Main control register fields
`define TLPIC_MAIN_HGEN     7
`define TLPIC_MAIN_LGEN     6
`define TLPIC_MAIN_T0IE     5
`define TLPIC_MAIN_P0IE     4
`define TLPIC_MAIN_PCIE     3
`define TLPIC_MAIN_T0IF     2
`define TLPIC_MAIN_P0IF     1
`define TLPIC_MAIN_PCIF     0
`define TLPIC_MAIN_RESET    8'h00

// Reset control register field
`define TLPIC_RCTL_PRIEN    7
`define TLPIC_RCTL_RESET    8'h00

// Vector addresses
`define TLPIC_VEC_HIGH      16'h0008
`define TLPIC_VEC_LOW       16'h0018

// Pin event latency, in instruction cycles (pclk edges)
`define TLPIC_PIN_LAT_CYC   3

`endif

//--- hdl/tlpic_sync.v
/*
 Two-flop synchroniser with rising-edge pulse output, one per bit.
 Assumes asynchronous inputs and a single pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tlpic_sync #(
   parameter W = 2
) (
   input  wire         pclk,     // Clock
   input  wire         presetn,  // Async reset, active low
   input  wire [W-1:0] async_in, // Raw pin levels
   output wire [W-1:0] rise      // One-cycle edge pulse
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign rise = s2_q & ~s3_q;
endmodule
`default_nettype wire

//--- hdl/tlpic_arb.v
/*
 Eligibility and priority arbitration for the interrupt sources.
 Assumes flags, enables and priorities are registered in pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tlpic_arb #(
   parameter N = 8
) (
   input  wire [N-1:0] flag,      // Source flags
   input  wire [N-1:0] en,        // Source enables
   input  wire [N-1:0] pri,       // Source priority, 1 = high
   input  wire [N-1:0] periph,    // Source is a peripheral
   input  wire         prio_mode, // Priority mode active
   input  wire         hi_gate,   // High or global enable
   input  wire         lo_gate,   // Low or peripheral enable
   input  wire         in_high,   // High routine in progress
   input  wire         in_low,    // Low routine in progress
   output wire         take_high, // Take a high request
   output wire         take_low   // Take a low request
);
   wire [N-1:0] act = flag & en;
   // Compatibility: peripherals need both enables, core sources need global
   wire [N-1:0] compat_ok = act & ~periph | act & periph & {N{lo_gate}};
   wire any_compat = hi_gate & (|compat_ok);
   wire any_hi = hi_gate & (|(act & pri));
   wire any_lo = hi_gate & lo_gate & (|(act & ~pri));
   // Priority bits ignored in compatibility mode
   assign take_high = prio_mode ? (any_hi & ~in_high)
                                : (any_compat & ~in_high & ~in_low);
   assign take_low  = prio_mode & any_lo & ~take_high
                      & ~in_high & ~in_low;
endmodule
`default_nettype wire

//--- verif/tlpic_properties.sv
/*
 Port-level checker for the interrupt controller top.
 Assumes binding onto tlpic_top, single pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tlpic_properties (
   input wire logic        pclk,     // Clock
   input wire logic        presetn,  // Async reset, active low
   input wire logic        psel,     // APB select
   input wire logic        penable,  // APB enable
   input wire logic        pready,   // APB ready
   input wire logic        pslverr,  // APB error
   input wire logic        vec_ack,  // Core took the vector
   input wire logic        vec_req,  // Vector request
   input wire logic [15:0] vec_addr, // Vector address
   input wire logic        push_ret  // Push return address
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_push_on_entry: assert property ($rose(vec_req) |-> push_ret)
      else $error("return push missing at entry");
   a_push_single: assert property (push_ret |=> !push_ret)
      else $error("return push longer than one cycle");
   a_push_needs_req: assert property (push_ret |-> vec_req)
      else $error("return push without vector request");
   a_req_held: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr))
      else $error("vector request dropped or moved before ack");
   a_vector_legal: assert property (vec_req |-> vec_addr == 16'h0008 || vec_addr == 16'h0018)
      else $error("vector address outside the two vectors");
   a_gap_after_ack: assert property (vec_req && vec_ack |=> !vec_req)
      else $error("request still high after ack");
   a_ready_access: assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   a_ready_only_access: assert property (pready |-> psel && penable)
      else $error("ready outside access cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
bind tlpic_top tlpic_properties i_tlpic_properties (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .vec_ack(vec_ack),
   .vec_req(vec_req), .vec_addr(vec_addr), .push_ret(push_ret));
`default_nettype wire

//--- verif/tlpic_core_model.sv
/*
 Core sequencer model: acknowledges vector requests, issues returns.
 Assumes the controller holds its request until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module tlpic_core_model (
   input  wire logic        pclk,            // Clock
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        vec_req,         // Vector request
   input  wire logic [15:0] vec_addr,        // Vector address
   input  wire logic        push_ret,        // Push return address
   input  wire logic [3:0]  ack_dly,         // Cycles before ack
   output var  logic        vec_ack,         // Vector taken
   output var  logic        return_from_isr  // Return pulse
);
   int          entries;
   int          cnt;
   logic [15:0] pc_q;
   // Entry counted on the push, so a slow ack still counts once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_ack <= 1'b0;
         cnt <= 0;
         entries <= 0;
         pc_q <= 16'h0000;
      end else begin
         vec_ack <= 1'b0;
         if (vec_req && !vec_ack) begin
            if (cnt >= ack_dly) begin
               vec_ack <= 1'b1;
               cnt <= 0;
            end else begin
               cnt <= cnt + 1;
            end
         end
         if (push_ret) begin
            entries <= entries + 1;
            pc_q <= vec_addr;
         end
      end
   end
   initial return_from_isr = 1'b0;
   task automatic do_ret;
      @(posedge pclk);
      return_from_isr <= 1'b1;
      @(posedge pclk);
      return_from_isr <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verif/tb_tlpic_top.sv
/*
 Self-checking bench for the interrupt controller top.
 Assumes the core model in tlpic_core_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tlpic_top;
   typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic err;} tlpic_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rdy, erv;
   logic        pin0_event, timer0_overflow, vec_ack, return_from_isr, vec_req, push_ret;
   logic        port_change;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [4:0]  periph_event;
   logic [15:0] vec_addr;
   logic [3:0]  ack_dly;
   int          failures, num_checks, n;
   tlpic_row_t  rows [8] = '{'{0, 12'h000, 0, 0}, '{0, 12'h004, 0, 0},
      '{0, 12'h010, 32'h0000_00ff, 0}, '{0, 12'h018, 0, 1}, '{1, 12'h018, 32'h0000_00aa, 1},
      '{1, 12'h00c, 32'h0000_001f, 0}, '{0, 12'h00c, 32'h0000_001f, 0}, '{0, 12'h014, 0, 0}};
   tlpic_top #(.NP(5)) i_tlpic_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin0_event(pin0_event), .port_change(port_change),
      .timer0_overflow(timer0_overflow), .periph_event(periph_event), .vec_ack(vec_ack),
      .return_from_isr(return_from_isr), .vec_req(vec_req), .vec_addr(vec_addr),
      .push_ret(push_ret));
   tlpic_core_model i_tlpic_core_model (.pclk(pclk), .presetn(presetn), .vec_req(vec_req),
      .vec_addr(vec_addr), .push_ret(push_ret), .ack_dly(ack_dly), .vec_ack(vec_ack),
      .return_from_isr(return_from_isr));
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // Answer taken at the edge that samples ready
      rdy = pready;
      rdv = prdata;
      erv = pslverr;
      psel <= 0;
      penable <= 0;
      check(rdy, 1, "no ready");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      check(rdv, exp, "read data");
   endtask
   task automatic wait_req;
      n = 0;
      do begin
         @(posedge pclk);
         #1 n++;
      end while (vec_req !== 1'b1 && n < 50);
      check(vec_req, 1, "no vector request");
   endtask
   task automatic pulse(input logic t, input logic [4:0] p);
      @(posedge pclk);
      timer0_overflow <= t;
      periph_event <= p;
      @(posedge pclk);
      timer0_overflow <= 0;
      periph_event <= 0;
   endtask
   task automatic quiet(input int e0);
      repeat (6) @(posedge pclk);
      check(i_tlpic_core_model.entries, e0, "unexpected entry");
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(5000 * 100);
      failures++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, pin0_event, port_change, timer0_overflow} = 0;
      {paddr, pwdata, periph_event, ack_dly} = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) check(rdv, rows[i].d, "register row");
         check(erv, rows[i].err, "error response");
      end
      $display("register table done");
      apb(1, 12'h010, 32'h0000_00fb);
      port_change <= 1;
      pulse(1, 0);
      rd(12'h000, 32'h0000_0005);
      port_change <= 0;
      quiet(0);
      apb(1, 12'h000, 32'h0000_00a4);
      wait_req;
      check(vec_addr, 16'h0008, "compat vector");
      rd(12'h000, 32'h0000_0024);
      apb(1, 12'h000, 32'h0000_0020);
      i_tlpic_core_model.do_ret();
      rd(12'h000, 32'h0000_00a0);
      pulse(0, 5'h01);
      quiet(1);
      apb(1, 12'h000, 32'h0000_00e0);
      wait_req;
      check(vec_addr, 16'h0008, "peripheral vector");
      apb(1, 12'h008, 0);
      i_tlpic_core_model.do_ret();
      $display("compatibility mode done");
      ack_dly <= 3;
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 32'h0000_0080);
      apb(1, 12'h000, 32'h0000_00f0);
      pulse(1, 0);
      wait_req;
      check(vec_addr, 16'h0018, "low vector");
      rd(12'h000, 32'h0000_00b4);
      check(i_tlpic_core_model.pc_q, 16'h0018, "loaded vector");
      @(posedge pclk);
      pin0_event <= 1;
      wait_req;
      check(vec_addr, 16'h0008, "preempt vector");
      check(n >= 3 && n <= 4, 1, "pin latency");
      rd(12'h000, 32'h0000_0036);
      // Pin back to idle so no edge follows the later reset
      pin0_event <= 0;
      apb(1, 12'h000, 32'h0000_00f4);
      quiet(4);
      apb(1, 12'h000, 32'h0000_0030);
      i_tlpic_core_model.do_ret();
      rd(12'h000, 32'h0000_00b0);
      i_tlpic_core_model.do_ret();
      rd(12'h000, 32'h0000_00f0);
      apb(1, 12'h000, 32'h0000_0060);
      pulse(1, 5'h01);
      quiet(4);
      apb(1, 12'h000, 32'h0000_00e4);
      wait_req;
      check(vec_addr, 16'h0008, "simultaneous vector");
      $display("priority mode done");
      @(posedge pclk);
      presetn <= 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rd(12'h000, 0);
      rd(12'h004, 0);
      check(vec_req, 0, "request after reset");
      $display("second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
